// file: dsa_pkg.sv
// Purpose: Shared constants for the data-space access unit.
// Assumes: 16-bit byte effective addresses, 16-bit data words.
// Notes:   Figures shared by the modules are named here; PCR_WORDS is set in the access unit.
package dsa_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam int          WREG_COUNT      = 16;
  localparam int          WREG_IDX_W      = 4;
  localparam int          DIRECT_FIELD_W  = 13;
  localparam int          MEM_BYTES       = 16384;
  localparam int          MEM_WORDS       = MEM_BYTES / 2;
  localparam int          MEM_IDX_W       = 13;
  localparam int          WINDOW_BIT      = 15;
  localparam logic [15:0] PCR_LAST_ADDR   = 16'h0fff;
  localparam logic [15:0] MEM_LAST_ADDR   = 16'h3fff;
  localparam logic [15:0] PCR_FIRST_IMPL  = 16'h0800;
  localparam logic [15:0] PCR_LAST_IMPL   = 16'h083f;
  localparam logic [15:0] STEP_BYTE       = 16'h0001;
  localparam logic [15:0] STEP_WORD       = 16'h0002;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [7:0]  BYTE_ONES       = 8'hff;

  typedef enum logic [1:0] {
    DSA_TGT_NONE = 2'h0,
    DSA_TGT_PCR  = 2'h1,
    DSA_TGT_MEM  = 2'h2,
    DSA_TGT_WIN  = 2'h3
  } dsa_target_type;

  typedef enum logic [1:0] {
    DSA_LOAD_WORD = 2'h0,
    DSA_LOAD_BYTE = 2'h1,
    DSA_LOAD_SEXT = 2'h2,
    DSA_LOAD_ZEXT = 2'h3
  } dsa_load_type;

  typedef enum logic [2:0] {
    DSA_TRAP_IDLE  = 3'b001,
    DSA_TRAP_FIN   = 3'b010,
    DSA_TRAP_TAKE  = 3'b100
  } dsa_trap_state_type;
endpackage

// file: dsa_address_generation_unit.sv
// Purpose: One address generator: direct or pointer address, with post-increment.
// Assumes: Pointer value is supplied by the working register file.
// Notes:   Read and write paths each instantiate one of these.
`timescale 1ns/1ns
module dsa_address_generation_unit (
  input  wire logic [15:0] source_pointer_register,
  input  wire logic [12:0] direct_field,
  input  wire logic [15:0] direct_long,
  input  wire logic [1:0]  mode,
  input  wire logic        is_byte,
  output logic      [15:0] effective_address,
  output logic      [15:0] pointer_updated
);
  // Mode 0 uses the pointer, 1 the short direct field, 2 and 3 the long direct field.
  always_comb begin
    case (mode)
      2'h1:    effective_address = {3'h0, direct_field};
      2'h2:    effective_address = direct_long;
      2'h3:    effective_address = direct_long;
      default: effective_address = source_pointer_register;
    endcase
    pointer_updated = source_pointer_register +
                      (is_byte ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD);
  end
endmodule // dsa_address_generation_unit

// file: dsa_decode.sv
// Purpose: Classify a byte effective address into a target region.
// Assumes: Implemented peripheral registers occupy a small sub-range.
// Notes:   Pure combinational decode.
`timescale 1ns/1ns
module dsa_decode (
  input  wire logic [15:0]         effective_address,
  output dsa_pkg::dsa_target_type  target
);
  always_comb begin
    if (effective_address[dsa_pkg::WINDOW_BIT]) begin
      target = dsa_pkg::DSA_TGT_WIN;
    end else if (effective_address <= dsa_pkg::PCR_LAST_ADDR) begin
      if (effective_address >= dsa_pkg::PCR_FIRST_IMPL &&
          effective_address <= dsa_pkg::PCR_LAST_IMPL) begin
        target = dsa_pkg::DSA_TGT_PCR;
      end else begin
        target = dsa_pkg::DSA_TGT_NONE;
      end
    end else if (effective_address <= dsa_pkg::MEM_LAST_ADDR) begin
      target = dsa_pkg::DSA_TGT_MEM;
    end else begin
      target = dsa_pkg::DSA_TGT_NONE;
    end
  end
endmodule // dsa_decode

// file: dsa_data_space_access_unit.sv
// Purpose: Data-space loads and stores for the primary core.
// Assumes: The execution unit presents one read and one write per cycle.
// Notes:   Reads are combinational from storage; results register one cycle later.
`timescale 1ns/1ns
module dsa_data_space_access_unit #(
  parameter int MEM_WORDS = dsa_pkg::MEM_WORDS,
  parameter int PCR_WORDS = 32
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          rd_valid,
  input  wire logic [1:0]                    rd_mode,
  input  wire logic                          rd_byte,
  input  wire logic [3:0]                    rd_ptr_sel,
  input  wire logic [12:0]                   rd_direct,
  input  wire logic [15:0]                   rd_direct_long,
  input  wire logic                          rd_post_inc,
  input  wire dsa_pkg::dsa_load_type         rd_load_kind,
  input  wire logic [3:0]                    rd_dest_sel,
  input  wire logic                          wr_valid,
  input  wire logic [1:0]                    wr_mode,
  input  wire logic                          wr_byte,
  input  wire logic [3:0]                    wr_ptr_sel,
  input  wire logic [12:0]                   wr_direct,
  input  wire logic [15:0]                   wr_direct_long,
  input  wire logic                          wr_post_inc,
  input  wire logic [15:0]                   wr_data,
  input  wire logic                          ext_valid,
  input  wire logic                          ext_sign,
  input  wire logic [3:0]                    ext_sel,
  input  wire logic                          wreg_load_valid,
  input  wire logic [3:0]                    wreg_load_sel,
  input  wire logic [15:0]                   wreg_load_data,
  input  wire logic                          addr_error_clear,
  input  wire logic [15:0]                   window_rdata,
  output logic      [15:0]                   window_addr,
  output logic                               window_rd,
  output logic      [15:0]                   rd_data,
  output logic                               rd_done,
  output logic                               wr_done,
  output logic                               addr_error_trap,
  output logic                               addr_error_flag,
  output logic      [3:0]                    wreg_peek_sel,
  output logic      [15:0]                   wreg_peek_data
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]  mem_lo [MEM_WORDS];
  logic [7:0]  mem_hi [MEM_WORDS];
  logic [7:0]  pcr_lo [PCR_WORDS];
  logic [7:0]  pcr_hi [PCR_WORDS];
  logic [15:0] wreg   [dsa_pkg::WREG_COUNT];

  // ----------------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------------
  logic [15:0]             rd_ea;
  logic [15:0]             wr_ea;
  logic [15:0]             rd_ptr_new;
  logic [15:0]             wr_ptr_new;
  dsa_pkg::dsa_target_type rd_tgt;
  dsa_pkg::dsa_target_type wr_tgt;

  dsa_address_generation_unit u_rd_agu (
    .source_pointer_register (wreg[rd_ptr_sel]),
    .direct_field            (rd_direct),
    .direct_long             (rd_direct_long),
    .mode                    (rd_mode),
    .is_byte                 (rd_byte),
    .effective_address       (rd_ea),
    .pointer_updated         (rd_ptr_new)
  );

  dsa_address_generation_unit u_wr_agu (
    .source_pointer_register (wreg[wr_ptr_sel]),
    .direct_field            (wr_direct),
    .direct_long             (wr_direct_long),
    .mode                    (wr_mode),
    .is_byte                 (wr_byte),
    .effective_address       (wr_ea),
    .pointer_updated         (wr_ptr_new)
  );

  dsa_decode u_rd_dec (
    .effective_address (rd_ea),
    .target            (rd_tgt)
  );

  dsa_decode u_wr_dec (
    .effective_address (wr_ea),
    .target            (wr_tgt)
  );

  // ----------------------------------------------------------------------
  // Word index and lane selection
  // ----------------------------------------------------------------------
  logic [12:0] rd_widx;
  logic [12:0] wr_widx;
  logic [4:0]  rd_pidx;
  logic [4:0]  wr_pidx;
  logic        rd_misalign;
  logic        wr_misalign;
  logic        wr_lo_en;
  logic        wr_hi_en;
  logic        wr_ok;

  assign rd_widx     = rd_ea[13:1];
  assign wr_widx     = wr_ea[13:1];
  assign rd_pidx     = rd_ea[5:1];
  assign wr_pidx     = wr_ea[5:1];
  assign rd_misalign = rd_valid && !rd_byte && rd_ea[0];
  assign wr_misalign = wr_valid && !wr_byte && wr_ea[0];
  assign wr_ok       = wr_valid && !wr_misalign;
  assign wr_lo_en    = wr_ok && (!wr_byte || !wr_ea[0]);
  assign wr_hi_en    = wr_ok && (!wr_byte || wr_ea[0]);

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [15:0] rd_word;
  logic [15:0] rd_aligned;
  logic [15:0] load_value;

  always_comb begin
    case (rd_tgt)
      dsa_pkg::DSA_TGT_MEM: rd_word = {mem_hi[rd_widx], mem_lo[rd_widx]};
      dsa_pkg::DSA_TGT_PCR: rd_word = {pcr_hi[rd_pidx], pcr_lo[rd_pidx]};
      dsa_pkg::DSA_TGT_WIN: rd_word = window_rdata;
      default:              rd_word = dsa_pkg::WORD_ZERO;
    endcase
    if (rd_byte) begin
      rd_aligned = {dsa_pkg::BYTE_ZERO, rd_ea[0] ? rd_word[15:8] : rd_word[7:0]};
    end else begin
      rd_aligned = rd_word;
    end
  end

  assign window_addr = rd_ea;
  assign window_rd   = rd_valid && (rd_tgt == dsa_pkg::DSA_TGT_WIN);

  always_comb begin
    case (rd_load_kind)
      dsa_pkg::DSA_LOAD_BYTE: load_value = {wreg[rd_dest_sel][15:8], rd_aligned[7:0]};
      dsa_pkg::DSA_LOAD_SEXT: load_value = {rd_aligned[7] ? dsa_pkg::BYTE_ONES
                                            : dsa_pkg::BYTE_ZERO, rd_aligned[7:0]};
      dsa_pkg::DSA_LOAD_ZEXT: load_value = {dsa_pkg::BYTE_ZERO, rd_aligned[7:0]};
      default:                load_value = rd_aligned;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= dsa_pkg::WORD_ZERO;
      rd_done <= 1'b0;
    end else begin
      rd_done <= rd_valid;
      if (rd_valid) begin
        rd_data <= rd_aligned;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (wr_tgt == dsa_pkg::DSA_TGT_MEM) begin
      if (wr_lo_en) begin
        mem_lo[wr_widx] <= wr_byte ? wr_data[7:0] : wr_data[7:0];
      end
      if (wr_hi_en) begin
        mem_hi[wr_widx] <= wr_byte ? wr_data[7:0] : wr_data[15:8];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PCR_WORDS; gi++) begin : g_pcr
      always_ff @(posedge clock) begin
        if (rst) begin
          pcr_lo[gi] <= dsa_pkg::BYTE_ZERO;
          pcr_hi[gi] <= dsa_pkg::BYTE_ZERO;
        end else if (wr_tgt == dsa_pkg::DSA_TGT_PCR && wr_pidx == 5'(gi)) begin
          if (wr_lo_en) begin
            pcr_lo[gi] <= wr_data[7:0];
          end
          if (wr_hi_en) begin
            pcr_hi[gi] <= wr_byte ? wr_data[7:0] : wr_data[15:8];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= wr_valid;
    end
  end

  // ----------------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------------
  // Priority, lowest first: external load, write pointer, read pointer,
  // memory load, extend operation.
  generate
    for (gi = 0; gi < dsa_pkg::WREG_COUNT; gi++) begin : g_wreg
      always_ff @(posedge clock) begin
        if (rst) begin
          wreg[gi] <= dsa_pkg::WORD_ZERO;
        end else if (ext_valid && ext_sel == 4'(gi)) begin
          wreg[gi] <= {ext_sign && wreg[gi][7] ? dsa_pkg::BYTE_ONES
                       : dsa_pkg::BYTE_ZERO, wreg[gi][7:0]};
        end else if (rd_valid && rd_dest_sel == 4'(gi)) begin
          wreg[gi] <= load_value;
        end else if (rd_valid && rd_post_inc && rd_mode == 2'h0 &&
                     rd_ptr_sel == 4'(gi)) begin
          wreg[gi] <= rd_ptr_new;
        end else if (wr_valid && wr_post_inc && wr_mode == 2'h0 &&
                     wr_ptr_sel == 4'(gi)) begin
          wreg[gi] <= wr_ptr_new;
        end else if (wreg_load_valid && wreg_load_sel == 4'(gi)) begin
          wreg[gi] <= wreg_load_data;
        end
      end
    end
  endgenerate

  assign wreg_peek_sel = ext_sel;

  always_ff @(posedge clock) begin
    if (rst) begin
      wreg_peek_data <= dsa_pkg::WORD_ZERO;
    end else begin
      wreg_peek_data <= wreg[ext_sel];
    end
  end

  // ----------------------------------------------------------------------
  // Address error trap
  // ----------------------------------------------------------------------
  dsa_pkg::dsa_trap_state_type trap_state_reg;
  dsa_pkg::dsa_trap_state_type trap_state_next;

  // The instruction finishes in the cycle after the fault; the trap follows.
  always_comb begin
    case (trap_state_reg)
      dsa_pkg::DSA_TRAP_IDLE: trap_state_next = (rd_misalign || wr_misalign)
                                                ? dsa_pkg::DSA_TRAP_FIN
                                                : dsa_pkg::DSA_TRAP_IDLE;
      dsa_pkg::DSA_TRAP_FIN:  trap_state_next = dsa_pkg::DSA_TRAP_TAKE;
      dsa_pkg::DSA_TRAP_TAKE: trap_state_next = dsa_pkg::DSA_TRAP_IDLE;
      default:                trap_state_next = dsa_pkg::DSA_TRAP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      trap_state_reg <= dsa_pkg::DSA_TRAP_IDLE;
    end else begin
      trap_state_reg <= trap_state_next;
    end
  end

  assign addr_error_trap = (trap_state_reg == dsa_pkg::DSA_TRAP_TAKE);

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_error_flag <= 1'b0;
    end else if (rd_misalign || wr_misalign) begin
      addr_error_flag <= 1'b1;
    end else if (addr_error_clear) begin
      addr_error_flag <= 1'b0;
    end
  end
endmodule // dsa_data_space_access_unit

// file: dsa_data_space_access_unit_sva.sv
// Purpose: Port-level checks for the data-space access unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Address checks use the 16-bit direct modes only.
`timescale 1ns/1ns
module dsa_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        rd_valid,
  input wire logic [1:0]  rd_mode,
  input wire logic        rd_byte,
  input wire logic [15:0] rd_direct_long,
  input wire logic        wr_valid,
  input wire logic [1:0]  wr_mode,
  input wire logic        wr_byte,
  input wire logic [15:0] wr_direct_long,
  input wire logic        addr_error_clear,
  input wire logic [15:0] window_addr,
  input wire logic        window_rd,
  input wire logic [15:0] rd_data,
  input wire logic        rd_done,
  input wire logic        wr_done,
  input wire logic        addr_error_trap,
  input wire logic        addr_error_flag
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_rd_done_follow: assert property (
    rd_valid |=> rd_done) else $error("read not completed");
  a_rd_done_cause: assert property (
    rd_done |-> $past(rd_valid)) else $error("stray read completion");
  a_wr_done_follow: assert property (
    wr_valid |=> wr_done) else $error("write not completed");
  a_misalign_flag: assert property (
    ((rd_valid && !rd_byte && rd_mode[1] && rd_direct_long[0])
     || (wr_valid && !wr_byte && wr_mode[1] && wr_direct_long[0]))
    |=> addr_error_flag) else $error("odd word access not flagged");
  a_trap_delay: assert property (
    $rose(addr_error_flag) |-> ##1 addr_error_trap) else $error("trap request missing");
  a_trap_single: assert property (
    addr_error_trap |=> !addr_error_trap) else $error("trap request too long");
  a_flag_sticky: assert property (
    (addr_error_flag && !addr_error_clear) |=> addr_error_flag) else $error("flag lost");
  a_window_route: assert property (
    (rd_valid && rd_mode[1]) |-> (window_rd == rd_direct_long[15]
     && window_addr == rd_direct_long)) else $error("window routing wrong");
  a_byte_low_lane: assert property (
    (rd_valid && rd_byte) |=> (rd_data[15:8] == 8'h00)) else $error("byte read upper not zero");
  a_unimpl_zero: assert property (
    (rd_valid && rd_mode[1] && rd_direct_long[15:14] == 2'h1) |=> (rd_data == 16'h0000))
    else $error("unimplemented read not zero");
endmodule // dsa_chk

// file: dsa_window_model.sv
// Purpose: Program-space window data source seen by the access unit.
// Assumes: Window data is combinational on the window address.
// Notes:   Data is a fixed scramble of the address.
`timescale 1ns/1ns
module dsa_window_model (
  input  wire logic [15:0] window_addr,
  input  wire logic        window_rd,
  output logic      [15:0] window_rdata
);
  // ----------------------------------------
  // Data
  // ----------------------------------------
  // Unselected data is inverted so a stale value never looks like a real read.
  assign window_rdata = window_rd ? (window_addr ^ 16'ha5c3) : ~(window_addr ^ 16'ha5c3);
endmodule // dsa_window_model

// file: tb.sv
// Purpose: Self-checking bench for the data-space access unit.
// Assumes: Inputs change on the falling edge.
// Notes:   Register 15 is a scratch destination for loads.
`timescale 1ns/1ns
module tb;
  logic clock = 1'b0, rst = 1'b1;
  logic rd_valid = 1'b0, rd_byte = 1'b0, rd_post_inc = 1'b0;
  logic wr_valid = 1'b0, wr_byte = 1'b0, wr_post_inc = 1'b0;
  logic ext_valid = 1'b0, ext_sign = 1'b0, wreg_load_valid = 1'b0, addr_error_clear = 1'b0;
  logic [1:0] rd_mode = 2'h0, wr_mode = 2'h0;
  logic [3:0] rd_ptr_sel = 4'h0, rd_dest_sel = 4'h0, wr_ptr_sel = 4'h0;
  logic [3:0] ext_sel = 4'h0, wreg_load_sel = 4'h0, wreg_peek_sel;
  logic [12:0] rd_direct = 13'h0, wr_direct = 13'h0;
  logic [15:0] rd_direct_long = 16'h0, wr_direct_long = 16'h0, wr_data = 16'h0;
  logic [15:0] wreg_load_data = 16'h0, window_rdata, window_addr, rd_data, wreg_peek_data;
  logic window_rd, rd_done, wr_done, addr_error_trap, addr_error_flag;
  dsa_pkg::dsa_load_type rd_load_kind = dsa_pkg::DSA_LOAD_WORD;
  logic [15:0] n_trap = 16'h0;
  int n_mismatch = 0, num_checks = 0;

  always #20 clock = ~clock;
  always @(posedge clock) if (addr_error_trap === 1'b1) n_trap <= n_trap + 16'h1;

  dsa_data_space_access_unit dsa_data_space_access_unit_inst (.clock, .rst, .rd_valid,
    .rd_mode, .rd_byte, .rd_ptr_sel, .rd_direct, .rd_direct_long, .rd_post_inc, .rd_load_kind,
    .rd_dest_sel, .wr_valid, .wr_mode, .wr_byte, .wr_ptr_sel, .wr_direct, .wr_direct_long,
    .wr_post_inc, .wr_data, .ext_valid, .ext_sign, .ext_sel, .wreg_load_valid,
    .wreg_load_sel, .wreg_load_data, .addr_error_clear, .window_rdata, .window_addr,
    .window_rd, .rd_data, .rd_done, .wr_done, .addr_error_trap, .addr_error_flag,
    .wreg_peek_sel, .wreg_peek_data);
  dsa_window_model dsa_window_model_inst (.window_addr, .window_rd, .window_rdata);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Mode 0 takes the pointer register from a[3:0] and post-increments it.
  task automatic rd(input logic [1:0] m, input logic b, input logic [15:0] a,
                    input dsa_pkg::dsa_load_type k, input logic [3:0] d, output logic [15:0] q);
    @(negedge clock);
    rd_valid = 1'b1;
    rd_mode = m;
    rd_byte = b;
    rd_ptr_sel = a[3:0];
    rd_direct = a[12:0];
    rd_direct_long = a;
    rd_post_inc = (m == 2'h0);
    rd_load_kind = k;
    rd_dest_sel = d;
    @(negedge clock);
    rd_valid = 1'b0;
    q = rd_data;
  endtask

  task automatic wr(input logic [1:0] m, input logic b, input logic [15:0] a,
                    input logic [15:0] v);
    @(negedge clock);
    wr_valid = 1'b1;
    wr_mode = m;
    wr_byte = b;
    wr_ptr_sel = a[3:0];
    wr_direct = a[12:0];
    wr_direct_long = a;
    wr_post_inc = (m == 2'h0);
    wr_data = v;
    @(negedge clock);
    wr_valid = 1'b0;
  endtask

  task automatic wl(input logic [3:0] s, input logic [15:0] v);
    @(negedge clock);
    wreg_load_valid = 1'b1;
    wreg_load_sel = s;
    wreg_load_data = v;
    @(negedge clock);
    wreg_load_valid = 1'b0;
  endtask

  task automatic ext(input logic sg, input logic [3:0] s);
    @(negedge clock);
    ext_valid = 1'b1;
    ext_sign = sg;
    ext_sel = s;
    @(negedge clock);
    ext_valid = 1'b0;
  endtask

  task automatic pk(input logic [3:0] s, output logic [15:0] q);
    @(negedge clock);
    ext_sel = s;
    @(negedge clock);
    q = wreg_peek_data;
  endtask

  task automatic clr();
    @(negedge clock);
    addr_error_clear = 1'b1;
    @(negedge clock);
    addr_error_clear = 1'b0;
    chk({15'h0, addr_error_flag}, 16'h0000);
  endtask

  task automatic t_mem();
    logic [15:0] q;
    wr(2'h2, 1'b0, 16'h1000, 16'h1234);
    chk({15'h0, wr_done}, 16'h0001);
    wr(2'h2, 1'b1, 16'h1001, 16'h00ab);
    rd(2'h2, 1'b0, 16'h1000, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'hab34);
    rd(2'h3, 1'b1, 16'h1001, dsa_pkg::DSA_LOAD_BYTE, 4'hf, q);
    chk(q, 16'h00ab);
    rd(2'h1, 1'b1, 16'h1000, dsa_pkg::DSA_LOAD_BYTE, 4'hf, q);
    chk(q, 16'h0034);
    wr(2'h1, 1'b1, 16'h1000, 16'h00cd);
    rd(2'h2, 1'b0, 16'h1000, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'habcd);
  endtask

  task automatic t_space();
    logic [15:0] q;
    wr(2'h2, 1'b0, 16'h5000, 16'h5555);
    rd(2'h2, 1'b0, 16'h1000, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'habcd);
    rd(2'h2, 1'b1, 16'h7fff, dsa_pkg::DSA_LOAD_BYTE, 4'hf, q);
    chk(q, 16'h0000);
    wr(2'h2, 1'b0, 16'h0100, 16'h7777);
    rd(2'h2, 1'b0, 16'h0100, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'h0000);
    wr(2'h2, 1'b0, 16'h0800, 16'h1357);
    rd(2'h2, 1'b0, 16'h0800, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'h1357);
    rd(2'h2, 1'b0, 16'h8010, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'h8010 ^ 16'ha5c3);
  endtask

  task automatic t_misalign();
    logic [15:0] q;
    wr(2'h2, 1'b0, 16'h1002, 16'h1111);
    wr(2'h2, 1'b0, 16'h1003, 16'hbeef);
    chk({15'h0, addr_error_flag}, 16'h0001);
    rd(2'h2, 1'b0, 16'h1002, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'h1111);
    repeat (3) @(negedge clock);
    chk(n_trap, 16'h0001);
    clr();
    rd(2'h2, 1'b0, 16'h1003, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk({15'h0, rd_done}, 16'h0001);
    repeat (4) @(negedge clock);
    chk(n_trap, 16'h0002);
    clr();
  endtask

  task automatic t_load();
    logic [15:0] q;
    wr(2'h2, 1'b0, 16'h1004, 16'h7f85);
    wl(4'h3, 16'h1234);
    rd(2'h2, 1'b1, 16'h1004, dsa_pkg::DSA_LOAD_BYTE, 4'h3, q);
    pk(4'h3, q);
    chk(q, 16'h1285);
    rd(2'h2, 1'b1, 16'h1004, dsa_pkg::DSA_LOAD_SEXT, 4'h7, q);
    pk(4'h7, q);
    chk(q, 16'hff85);
    rd(2'h2, 1'b1, 16'h1005, dsa_pkg::DSA_LOAD_ZEXT, 4'h7, q);
    pk(4'h7, q);
    chk(q, 16'h007f);
    wl(4'h8, 16'h12f0);
    ext(1'b1, 4'h8);
    pk(4'h8, q);
    chk(q, 16'hfff0);
    chk({12'h000, wreg_peek_sel}, 16'h0008);
    ext(1'b0, 4'h8);
    pk(4'h8, q);
    chk(q, 16'h00f0);
  endtask

  task automatic t_ptr();
    logic [15:0] q;
    wl(4'h5, 16'h1000);
    rd(2'h0, 1'b1, 16'h0005, dsa_pkg::DSA_LOAD_BYTE, 4'hf, q);
    chk(q, 16'h00cd);
    pk(4'h5, q);
    chk(q, 16'h1001);
    wl(4'h6, 16'h1010);
    wr(2'h0, 1'b0, 16'h0006, 16'h2468);
    pk(4'h6, q);
    chk(q, 16'h1012);
    wl(4'h5, 16'h1010);
    rd(2'h0, 1'b0, 16'h0005, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'h2468);
    pk(4'h5, q);
    chk(q, 16'h1012);
  endtask

  // A read and a write through two pointers, taken at the same edge.
  task automatic t_dual();
    logic [15:0] q;
    wl(4'h9, 16'h1020);
    wl(4'ha, 16'h1004);
    fork
      wr(2'h0, 1'b0, 16'h0009, 16'h55aa);
      rd(2'h0, 1'b0, 16'h000a, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    join
    chk(q, 16'h7f85);
    rd(2'h3, 1'b0, 16'h1020, dsa_pkg::DSA_LOAD_WORD, 4'hf, q);
    chk(q, 16'h55aa);
    pk(4'h9, q);
    chk(q, 16'h1022);
    pk(4'ha, q);
    chk(q, 16'h1006);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_mem();
    t_space();
    t_misalign();
    t_load();
    t_ptr();
    t_dual();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
endmodule // tb

bind dsa_data_space_access_unit dsa_chk dsa_chk_inst (.clock(clock), .rst(rst),
  .rd_valid(rd_valid), .rd_mode(rd_mode), .rd_byte(rd_byte), .rd_direct_long(rd_direct_long),
  .wr_valid(wr_valid), .wr_mode(wr_mode), .wr_byte(wr_byte), .wr_direct_long(wr_direct_long),
  .addr_error_clear(addr_error_clear), .window_addr(window_addr), .window_rd(window_rd),
  .rd_data(rd_data), .rd_done(rd_done), .wr_done(wr_done),
  .addr_error_trap(addr_error_trap), .addr_error_flag(addr_error_flag));
